// >>> rtl/isp_consts.svh
// Purpose: constants of the supply protection sequencer
// Assumes: included by bare name
// Notes: offsets are byte addresses on the register bus
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ISP_OFF_CTRL 12'h000
`define ISP_OFF_STATUS 12'h004
`define ISP_OFF_CAUSE 12'h008
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define ISP_CTRL_RUN_BIT 0
`define ISP_CTRL_RST 32'h0000_0001
`define ISP_REF_STEP_LAST 3'h7
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ISP_CLK_MHZ 125
`define ISP_ENA_LOW_US 150
`define ISP_SS_TIMEOUT_US 16000
`define ISP_REF_STEP_US 128
`endif

// >>> rtl/isp_pkg.sv
// Purpose: types of the supply protection sequencer
// Assumes: nothing
// Notes: comparator bits are raw asynchronous levels
package isp_pkg;
   // operating states
   typedef enum logic [2:0] {
      ST_UVLO, ST_DISABLED, ST_SOFTSTART, ST_RUN, ST_OVLO, ST_LATCHED
   } isp_state_t;
   // comparator results, one bit per threshold
   typedef struct packed {
      logic vin_below_uv_fall;
      logic vin_above_uv_rise;
      logic vin_below_reset;
      logic vin_above_ov_rise;
      logic vin_below_ov_fall;
      logic main_fb_over;
      logic aux_fb_over;
      logic failsafe_over;
      logic main_fb_under;
      logic aux_fb_under;
      logic main_fb_recovered;
      logic aux_fb_recovered;
      logic primary_overtemp;
      logic secondary_overtemp;
      logic main_above_uvlos;
      logic main_above_uvp;
      logic main_in_window;
      logic aux_in_window;
   } isp_cmp_t;
   // latched fault causes
   typedef struct packed {
      logic overtemp;
      logic ss_timeout;
      logic ss_incomplete;
      logic fb_under;
      logic failsafe;
      logic fb_over;
   } isp_cause_t;
endpackage : isp_pkg

// >>> rtl/isp_sequencer.sv
// Purpose: enable, power-good and protection sequencer
// Assumes: comparator and enable inputs are asynchronous levels
// Notes: analog loops, carrier and ramp shaping live elsewhere
//
// Operation
// [R1] enable high, no latch: soft-start then run
// [R2] enable low stops switching, disabled
// [R3] enable low over 150 us then high clears
// [R4] toggle clears latch only without faults
// [R5] power-good only fault-free and in window
// [R6] input uv/ov recover, others latch
// [R7] latched: stopped; toggle or vin recycle clears
// [R8] vin below uv fall: lockout, stop
// [R9] vin below reset level clears protections
// [R10] after uv rise: start if enabled
// [R11] input ov stops; recovery restarts if enabled
// [R12] input ov keeps other latched faults
// [R13] feedback overvoltage stops and latches
// [R14] fail-safe output overvoltage latches off
// [R15] feedback undervoltage outside soft-start latches
// [R16] soft-start end below recovery latches
// [R17] overtemperature stops, releases, latches
// [R18] overtemp latch clears after cooling plus recycle
// [R19] no uvlos level within 16 ms latches
// [R20] main past uvp: power-good, aux regulator
// [R21] reference steps seven times, 128 us each
// [R22] comparator inputs synchronised before use
// [R23] power-good released when not switching
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "isp_consts.svh"
module isp_sequencer
   import isp_pkg::*;
#(
   parameter int ENA_LOW_CYC = `ISP_ENA_LOW_US * `ISP_CLK_MHZ,
   parameter int SS_TIMEOUT_CYC = `ISP_SS_TIMEOUT_US * `ISP_CLK_MHZ,
   parameter int REF_STEP_CYC = `ISP_REF_STEP_US * `ISP_CLK_MHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins and comparators
   input wire logic converter_enable_in,
   input wire isp_cmp_t cmp_in,
   output logic power_good_n_o,
   output logic power_good_n_oe,
   output logic switching_on,
   output logic aux_regulator_on,
   output logic [2:0] fb_reference_step,
   output isp_state_t seq_state
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (ENA_LOW_CYC < 1 || SS_TIMEOUT_CYC < 1 || REF_STEP_CYC < 1)
   begin : g_bad_count
      $error("isp_sequencer: counts must be at least one");
   end

   localparam int SYN_W = $bits(isp_cmp_t) + 1;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [SYN_W-1:0] sync1_q; // first stage, read by sync2 only
   logic [SYN_W-1:0] sync2_q;
   logic [SYN_W-1:0] sync3_q;
   logic [SYN_W-1:0] filt_q; // accepted levels
   isp_cmp_t c; // accepted comparator view
   logic en_f; // accepted enable level
   logic en_prev_q; // enable one cycle ago

   // three flop stages per input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else if (clk_en) begin
         sync1_q <= {converter_enable_in, cmp_in}; // [R22]
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // filter: per bit, update only where stage two equals three
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q <= '0;
      end else if (clk_en) begin
         filt_q <= (filt_q & ~(sync2_q ~^ sync3_q)) |
                   (sync3_q & (sync2_q ~^ sync3_q)); // [R22]
      end
   end

   assign c = isp_cmp_t'(filt_q[SYN_W-2:0]);
   assign en_f = filt_q[SYN_W-1];

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q; // software control word
   isp_cause_t cause_q; // sticky causes, write one to clear
   isp_cause_t cause_set; // causes raised this cycle
   logic run_permit; // software gate on the enable pin
   logic acc_wr; // write access phase
   logic hit_ctrl;
   logic hit_status;
   logic hit_cause;

   assign run_permit = ctrl_q[`ISP_CTRL_RUN_BIT];
   assign acc_wr = psel & penable & pwrite & clk_en;
   assign hit_ctrl = (paddr == `ISP_OFF_CTRL);
   assign hit_status = (paddr == `ISP_OFF_STATUS);
   assign hit_cause = (paddr == `ISP_OFF_CAUSE);

   // slave answers in the first access cycle unless frozen
   assign pready = clk_en;
   assign pslverr = psel & penable & ~(hit_ctrl | hit_status | hit_cause);

   // control word: only the run bit is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `ISP_CTRL_RST;
      end else if (acc_wr && hit_ctrl) begin
         ctrl_q <= {31'h0, pwdata[`ISP_CTRL_RUN_BIT]};
      end
   end

   // ------------------------------------------------------------
   // input lockouts
   // ------------------------------------------------------------
   logic uv_lock_q; // input undervoltage lockout held
   logic ov_lock_q; // input overvoltage lockout held
   logic reset_lvl; // vin below reset level

   assign reset_lvl = c.vin_below_reset;

   // lockout starts held so a power-up passes the rising level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_lock_q <= 1'b1;
      end else if (clk_en) begin
         if (c.vin_below_uv_fall || reset_lvl) begin
            uv_lock_q <= 1'b1; // [R8]
         end else if (c.vin_above_uv_rise) begin
            uv_lock_q <= 1'b0; // [R6] [R10]
         end
      end
   end

   // overvoltage lockout with its own hysteresis
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_lock_q <= 1'b0;
      end else if (clk_en) begin
         if (c.vin_above_ov_rise) begin
            ov_lock_q <= 1'b1; // [R11]
         end else if (c.vin_below_ov_fall) begin
            ov_lock_q <= 1'b0; // [R6] [R11]
         end
      end
   end

   // ------------------------------------------------------------
   // enable low timer
   // ------------------------------------------------------------
   logic [31:0] en_low_cnt_q; // cycles enable has been low
   logic en_low_long; // low for more than the clear time
   logic en_rise;

   assign en_rise = en_f & ~en_prev_q;
   assign en_low_long = (en_low_cnt_q > 32'(ENA_LOW_CYC)); // [R3]

   // saturating count, restarted whenever enable is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_low_cnt_q <= '0;
         en_prev_q <= 1'b0;
      end else if (clk_en) begin
         en_prev_q <= en_f;
         if (en_f) begin
            en_low_cnt_q <= '0;
         end else if (!en_low_long) begin
            en_low_cnt_q <= en_low_cnt_q + 32'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // fault latch
   // ------------------------------------------------------------
   logic latch_q; // latched-off protection held
   logic fault_now; // a latching condition is present now
   logic toggle_clear; // enable off-then-on clears the latch

   // cooling below recovery shows as the overtemp bits low
   assign fault_now = c.main_fb_over | c.aux_fb_over | c.failsafe_over |
                      c.primary_overtemp | c.secondary_overtemp;
   assign toggle_clear = latch_q & en_rise & en_low_long &
                         ~fault_now; // [R3] [R4] [R18]

   // a new cause wins over a toggle clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 1'b0;
      end else if (clk_en) begin
         if (reset_lvl) begin
            latch_q <= 1'b0; // [R9] [R7]
         end else if (|cause_set) begin
            latch_q <= 1'b1; // [R6]
         end else if (toggle_clear) begin
            latch_q <= 1'b0; // [R7]
         end
      end
   end

   // sticky causes for software; set beats write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= '0;
      end else if (clk_en) begin
         if (reset_lvl) begin
            cause_q <= '0; // [R9]
         end else if (acc_wr && hit_cause) begin
            cause_q <= (cause_q & ~isp_cause_t'(pwdata[5:0])) | cause_set;
         end else begin
            cause_q <= cause_q | cause_set;
         end
      end
   end

   // ------------------------------------------------------------
   // soft-start timing
   // ------------------------------------------------------------
   isp_state_t state_q;
   isp_state_t state_d;
   logic [31:0] ss_cnt_q; // cycles since soft-start began
   logic [31:0] step_cnt_q; // cycles on the present step
   logic [2:0] step_q; // reference step, 0 is the lowest
   logic uvlos_seen_q; // main output passed the uvlos level
   logic ss_done; // last reference step reached
   logic in_ss;

   assign in_ss = (state_q == ST_SOFTSTART);
   assign ss_done = (step_q == `ISP_REF_STEP_LAST);

   // counters run in soft-start; the step keeps its top in run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ss_cnt_q <= '0;
         step_cnt_q <= '0;
         step_q <= '0;
      end else if (clk_en) begin
         if (!in_ss) begin
            ss_cnt_q <= '0;
            step_cnt_q <= '0;
            if (state_q != ST_RUN) begin
               step_q <= '0; // [R21]
            end
         end else begin
            if (ss_cnt_q < 32'(SS_TIMEOUT_CYC)) begin
               ss_cnt_q <= ss_cnt_q + 32'h1;
            end
            if (step_cnt_q == 32'(REF_STEP_CYC - 1) && !ss_done) begin
               step_cnt_q <= '0;
               step_q <= step_q + 3'h1; // [R21]
            end else begin
               step_cnt_q <= step_cnt_q + 32'h1;
            end
         end
      end
   end

   // uvlos level seen in this start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uvlos_seen_q <= 1'b0;
      end else if (clk_en) begin
         if (!in_ss) begin
            uvlos_seen_q <= 1'b0;
         end else if (c.main_above_uvlos) begin
            uvlos_seen_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // trip detection and next state
   // ------------------------------------------------------------
   logic switching; // power stage allowed to run
   logic go; // enable pin high and software permits

   assign switching = (state_q == ST_SOFTSTART) || (state_q == ST_RUN);
   assign go = en_f & run_permit;

   // trips only while powered; lockouts keep the latch untouched
   always_comb begin
      cause_set = '0;
      if (!uv_lock_q && !ov_lock_q && !reset_lvl) begin
         if (state_q != ST_UVLO && state_q != ST_OVLO) begin
            cause_set.overtemp = c.primary_overtemp |
                                 c.secondary_overtemp; // [R17]
         end
         if (switching) begin
            cause_set.fb_over = c.main_fb_over | c.aux_fb_over; // [R13]
            cause_set.failsafe = c.failsafe_over; // [R14]
         end
         if (state_q == ST_RUN) begin
            cause_set.fb_under = c.main_fb_under | c.aux_fb_under; // [R15]
         end
         if (in_ss) begin
            // undervoltage masked until the ramp is finished
            cause_set.ss_incomplete = ss_done &&
               (!c.main_fb_recovered || !c.aux_fb_recovered); // [R16]
            cause_set.ss_timeout = !uvlos_seen_q &&
               !c.main_above_uvlos &&
               (ss_cnt_q >= 32'(SS_TIMEOUT_CYC - 1)); // [R19]
         end
      end
   end

   // lockouts take priority, then the latch, then the enable
   always_comb begin
      state_d = state_q;
      if (reset_lvl || uv_lock_q) begin
         state_d = ST_UVLO; // [R8]
      end else if (ov_lock_q) begin
         state_d = ST_OVLO; // [R11] [R12]
      end else if (|cause_set) begin
         state_d = ST_LATCHED; // [R17]
      end else begin
         case (state_q)
            ST_UVLO, ST_OVLO, ST_DISABLED: begin
               if (latch_q) begin
                  state_d = ST_LATCHED; // [R12]
               end else if (go) begin
                  state_d = ST_SOFTSTART; // [R1] [R10] [R11]
               end else begin
                  state_d = ST_DISABLED; // [R10]
               end
            end
            ST_LATCHED: begin
               if (!latch_q) begin
                  state_d = go ? ST_SOFTSTART : ST_DISABLED; // [R18]
               end
            end
            ST_SOFTSTART: begin
               if (!go) begin
                  state_d = ST_DISABLED; // [R2]
               end else if (ss_done) begin
                  state_d = ST_RUN; // [R1]
               end
            end
            ST_RUN: begin
               if (!go) begin
                  state_d = ST_DISABLED; // [R2]
               end
            end
            default: begin
               state_d = ST_UVLO;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_UVLO;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic switch_q; // power stage drive
   logic aux_en_q; // auxiliary regulator enable
   logic pg_q; // power-good asserted

   // switching follows the next state so a trip stops it at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_q <= 1'b0;
      end else if (clk_en) begin
         switch_q <= (state_d == ST_SOFTSTART) ||
                     (state_d == ST_RUN); // [R7] [R13] [R14]
      end
   end

   // aux regulator comes up once main passes its uvp level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_en_q <= 1'b0;
      end else if (clk_en) begin
         if (state_d != ST_SOFTSTART && state_d != ST_RUN) begin
            aux_en_q <= 1'b0;
         end else if (state_d == ST_SOFTSTART && c.main_above_uvp) begin
            aux_en_q <= 1'b1; // [R20]
         end
      end
   end

   // power-good: switching, aux up, no fault, both rails in window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_q <= 1'b0;
      end else if (clk_en) begin
         pg_q <= ((state_d == ST_SOFTSTART && c.main_above_uvp) ||
                  (state_d == ST_RUN && aux_en_q)) && // [R20] [R23]
                 !fault_now && c.main_in_window &&
                 c.aux_in_window; // [R5]
      end
   end

   // open drain: pull low only while power is good
   assign power_good_n_o = 1'b0;
   assign power_good_n_oe = pg_q; // [R5] [R15] [R17]
   assign switching_on = switch_q;
   assign aux_regulator_on = aux_en_q;
   assign fb_reference_step = step_q; // [R21]
   assign seq_state = state_q;

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // registered read data, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (clk_en && psel && !penable) begin
         if (hit_ctrl) begin
            prdata <= ctrl_q;
         end else if (hit_status) begin
            prdata <= {19'h0, step_q, en_f, pg_q, aux_en_q, switch_q,
                       ov_lock_q, uv_lock_q, latch_q, state_q};
         end else if (hit_cause) begin
            prdata <= {26'h0, cause_q};
         end else begin
            prdata <= '0;
         end
      end
   end
endmodule : isp_sequencer

// >>> test/isp_seq_asserts.sv
// Purpose: port level checks of the supply protection sequencer
// Assumes: bound to the top module, sees its ports only
// Notes: raw inputs reach the state about five edges late
`timescale 1ns/1ps
`include "isp_consts.svh"
module isp_seq_asserts
   import isp_pkg::*;
#(
   parameter int ENA_LOW_CYC = 20,
   parameter int SS_TIMEOUT_CYC = 200,
   parameter int REF_STEP_CYC = 8
) (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic [11:0] paddr,
   input logic pslverr,
   input logic converter_enable_in,
   input isp_cmp_t cmp_in,
   input logic power_good_n_oe,
   input logic switching_on,
   input logic [2:0] fb_reference_step,
   input isp_state_t seq_state
);
   // --------------------
   // helper logic
   // --------------------
   logic fault; // feedback overvoltage, fail-safe or overtemperature present
   logic quiet; // input supply inside its window
   logic [15:0] ss_cnt_q; // soft-start cycles without uvlos level
   assign fault = cmp_in.main_fb_over | cmp_in.aux_fb_over |
      cmp_in.failsafe_over | cmp_in.primary_overtemp |
      cmp_in.secondary_overtemp;
   assign quiet = !cmp_in.vin_below_uv_fall && !cmp_in.vin_below_reset &&
      !cmp_in.vin_above_ov_rise;
   // raw count; the filtered view lags, so the bound has slack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ss_cnt_q <= 16'h0000;
      end else if (seq_state == ST_SOFTSTART &&
                   !cmp_in.main_above_uvlos) begin
         ss_cnt_q <= ss_cnt_q + 16'h0001;
      end else begin
         ss_cnt_q <= 16'h0000;
      end
   end
   // --------------------
   // assertions
   // --------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pg_only_on: assert property (power_good_n_oe |->
      seq_state inside {ST_SOFTSTART, ST_RUN}) else $error("pg while off");
   a_latch_stops: assert property (seq_state == ST_LATCHED [*2] |->
      !switching_on) else $error("switching while latched");
   a_idle_off: assert property (seq_state inside
      {ST_UVLO, ST_DISABLED, ST_OVLO} [*2] |->
      !switching_on && !power_good_n_oe) else $error("idle not off");
   a_fault_trips: assert property (fault && quiet &&
      seq_state inside {ST_SOFTSTART, ST_RUN} ##1 (fault && quiet) [*7]
      |-> seq_state == ST_LATCHED) else $error("fault did not latch");
   a_latch_holds: assert property ((fault && quiet) [*6] ##0
      seq_state == ST_LATCHED |=> seq_state == ST_LATCHED)
      else $error("latch left with fault");
   a_ref_steps: assert property (seq_state == ST_SOFTSTART &&
      $past(seq_state) == ST_SOFTSTART && $changed(fb_reference_step)
      |-> fb_reference_step == $past(fb_reference_step) + 3'h1)
      else $error("reference skipped a step");
   a_ss_bound: assert property (ss_cnt_q <= SS_TIMEOUT_CYC + 8)
      else $error("soft-start overran its limit");
   a_pg_fault: assert property (fault [*8] |-> !power_good_n_oe)
      else $error("pg with fault");
   a_en_low_off: assert property (!converter_enable_in [*8] |->
      !switching_on) else $error("switching with enable low");
   a_bus_refuse: assert property (psel && penable |-> pslverr ==
      !(paddr inside {`ISP_OFF_CTRL, `ISP_OFF_STATUS, `ISP_OFF_CAUSE}))
      else $error("slave error on wrong address");
   // main scenarios reached
   c_run: cover property (seq_state == ST_RUN);
   c_latched: cover property (seq_state == ST_LATCHED);
   c_ovlo: cover property (seq_state == ST_OVLO);
endmodule : isp_seq_asserts
bind isp_sequencer isp_seq_asserts #(.ENA_LOW_CYC(ENA_LOW_CYC),
   .SS_TIMEOUT_CYC(SS_TIMEOUT_CYC), .REF_STEP_CYC(REF_STEP_CYC)) u_asserts (
   .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .converter_enable_in,
   .cmp_in, .power_good_n_oe, .switching_on, .fb_reference_step, .seq_state);

// >>> test/isp_host_model.sv
// Purpose: host side of the enable and power-good pins
// Assumes: enable requests come from the bench
// Notes: pin has a pull-up, so a released pin reads high
`timescale 1ns/1ps
module isp_host_model (
   input logic pclk,
   input logic en_req,
   input logic power_good_n_o,
   input logic power_good_n_oe,
   output logic converter_enable_in,
   output logic power_good_pin
);
   // enable moves just after an edge; low time is set by the bench
   initial converter_enable_in = 1'b0;
   always @(posedge pclk) begin
      converter_enable_in <= en_req;
   end
   // open-drain pin resolved against the pull-up
   assign power_good_pin = power_good_n_oe ? power_good_n_o : 1'b1;
endmodule : isp_host_model

// >>> test/test_isolated_supply_protection_fsm.sv
// Purpose: self-checking bench of the protection sequencer
// Assumes: short test counts, clk_en held high
// Notes: waits of 12 cover the input filter latency
`timescale 1ns/1ps
`include "isp_consts.svh"
module test_isolated_supply_protection_fsm
   import isp_pkg::*;
;
   // --------------------
   // signals
   // --------------------
   // good supply: uv rise, ov fall, recovered, uvlos, uvp, windows
   localparam logic [17:0] GOOD = 18'h120cf;
   logic pclk = 1'b0;
   logic presetn, clk_en, psel, penable, pwrite, en_req, en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, e, pg_o, pg_oe, pg_pin, sw, aux;
   logic [2:0] step;
   isp_cmp_t cmp;
   isp_state_t st;
   int err_count = 0;
   int checked = 0;
   int fpos[7] = '{12, 11, 10, 9, 8, 5, 4}; // fault bit positions
   logic [31:0] fcause[7] = '{32'h1, 32'h1, 32'h2, 32'h4, 32'h4, 32'h20,
      32'h20};
   always #4 pclk = ~pclk;
   isp_sequencer #(.ENA_LOW_CYC(20), .SS_TIMEOUT_CYC(40),
      .REF_STEP_CYC(8)) u_dut (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .converter_enable_in(en), .cmp_in(cmp),
      .power_good_n_o(pg_o), .power_good_n_oe(pg_oe), .switching_on(sw),
      .aux_regulator_on(aux), .fb_reference_step(step), .seq_state(st));
   isp_host_model u_host (.pclk(pclk), .en_req(en_req),
      .power_good_n_o(pg_o), .power_good_n_oe(pg_oe),
      .converter_enable_in(en), .power_good_pin(pg_pin));
   // --------------------
   // tasks
   // --------------------
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic stc(input isp_state_t exp);
      chk("state", {29'h0, st}, {29'h0, exp});
   endtask : stc
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, q, exp);
   endtask : rdc
   // enable low for n cycles, then high and settle
   task automatic tog(input int n);
      en_req <= 1'b0;
      wt(n);
      en_req <= 1'b1;
      wt(12);
   endtask : tog
   task automatic end_of_test;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // --------------------
   // sequence
   // --------------------
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      en_req = 1'b0;
      cmp = GOOD;
      wt(5);
      presetn <= 1'b1;
      wt(12);
      stc(ST_DISABLED);
      chk("pg pin", pg_pin, 32'h1);
      rdc("ctrl", `ISP_OFF_CTRL, `ISP_CTRL_RST);
      rdc("unmapped", 12'hffc, 32'h0);
      chk("slave error", e, 32'h1);
      en_req <= 1'b1;
      wt(12);
      stc(ST_SOFTSTART);
      chk("switching", sw, 32'h1);
      wt(70);
      stc(ST_RUN);
      chk("ref step", step, 32'h7);
      chk("pg pin", pg_pin, 32'h0);
      chk("aux on", aux, 32'h1);
      en_req <= 1'b0;
      wt(12);
      stc(ST_DISABLED);
      chk("switching", sw, 32'h0);
      en_req <= 1'b1;
      wt(80);
      // each latching fault from run, then the clearing rules
      for (int i = 0; i < 7; i++) begin
         cmp <= GOOD | (18'h1 << fpos[i]);
         wt(12);
         stc(ST_LATCHED);
         chk("switching", sw, 32'h0);
         chk("pg pin", pg_pin, 32'h1);
         rdc("cause", `ISP_OFF_CAUSE, fcause[i]);
         // undervoltage is masked in soft-start, so skip it here
         if (i != 3 && i != 4) begin
            tog(30);
            stc(ST_LATCHED);
         end
         cmp <= GOOD;
         wt(12);
         tog(5);
         stc(ST_LATCHED);
         tog(30);
         stc(ST_SOFTSTART);
         apb(1'b1, `ISP_OFF_CAUSE, 32'h3f);
         rdc("cause", `ISP_OFF_CAUSE, 32'h0);
         wt(80);
      end
      cmp <= GOOD ^ 18'h6000;
      wt(12);
      stc(ST_OVLO);
      cmp <= GOOD;
      wt(12);
      stc(ST_SOFTSTART);
      cmp <= GOOD | 18'h400;
      wt(12);
      cmp <= GOOD ^ 18'h6000;
      wt(12);
      cmp <= GOOD;
      wt(12);
      stc(ST_LATCHED);
      cmp <= GOOD ^ 18'h38000;
      wt(12);
      stc(ST_UVLO);
      chk("switching", sw, 32'h0);
      rdc("cause", `ISP_OFF_CAUSE, 32'h0);
      cmp <= GOOD;
      wt(12);
      stc(ST_SOFTSTART);
      wt(80);
      cmp <= GOOD ^ 18'h80;
      tog(30);
      wt(70);
      stc(ST_LATCHED);
      rdc("cause", `ISP_OFF_CAUSE, 32'h8);
      cmp <= GOOD ^ 18'h8;
      apb(1'b1, `ISP_OFF_CAUSE, 32'h3f);
      tog(30);
      wt(50);
      stc(ST_LATCHED);
      rdc("cause", `ISP_OFF_CAUSE, 32'h10);
      end_of_test();
   end
   // watchdog: ten times the sequence
   initial begin
      wt(20000);
      err_count++;
      end_of_test();
   end
endmodule : test_isolated_supply_protection_fsm
